// *** led_timer_pkg.sv ***
// Constants, field layout and period tables for the LED timer block
package led_timer_pkg;

  // ----------------------------------------------------------------
  // Clock and base tick
  // ----------------------------------------------------------------
  localparam int CLK_MHZ   = 200;
  localparam int TICK_US   = 1000;
  localparam int MS_CYCLES = TICK_US * CLK_MHZ;
  localparam int PER_W     = 11;

  // ----------------------------------------------------------------
  // Register map (offsets are word indices)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LEDPOL  = 8'h11;
  localparam logic [7:0] IDX_TIMER   = 8'h12;
  localparam logic [7:0] IDX_STATUS  = 8'h13;
  localparam logic [7:0] ADDR_LEDPOL = 8'(IDX_LEDPOL * 4);
  localparam logic [7:0] ADDR_TIMER  = 8'(IDX_TIMER * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);

  // ----------------------------------------------------------------
  // Timer control and LED polarity fields
  // ----------------------------------------------------------------
  localparam int FORCE_BIT = 15;
  localparam int STR_HI    = 14;
  localparam int STR_LO    = 12;
  localparam int POL_BIT   = 11;
  localparam int BLINK_HI  = 10;
  localparam int BLINK_LO  = 8;
  localparam int INTEN_BIT = 7;
  localparam int OFF_HI    = 3;
  localparam int OFF_LO    = 2;
  localparam int ON_HI     = 1;
  localparam int ON_LO     = 0;
  localparam int LPOL_HI   = 5;
  localparam int LPOL_LO   = 4;

  localparam logic [15:0] TIMER_RST   = 16'h4905;
  localparam logic [15:0] TIMER_WMASK = 16'hFF8F;
  localparam logic [15:0] LEDPOL_RST  = 16'h0000;
  localparam logic [15:0] LEDPOL_WMASK = 16'h0030;

  // ----------------------------------------------------------------
  // Period tables in ms
  // ----------------------------------------------------------------
  typedef logic [PER_W-1:0] per_t;
  localparam per_t STRETCH_MS [0:7] = '{11'd21, 11'd21, 11'd42, 11'd84,
                                        11'd170, 11'd340, 11'd670,
                                        11'd1300};
  // Reserved blink codes fall back to the slowest rate
  localparam per_t BLINK_MS [0:7] = '{11'd42, 11'd84, 11'd170, 11'd340,
                                      11'd670, 11'd670, 11'd670,
                                      11'd670};
  localparam per_t SPEED_MS [0:3] = '{11'd84, 11'd170, 11'd340, 11'd670};

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    STR_IDLE = 3'b001,
    STR_ARM  = 3'b010,
    STR_HOLD = 3'b100
  } stretch_state_t;

  typedef enum logic [1:0]
  {
    SPD_OFF = 2'b01,
    SPD_ON  = 2'b10
  } speed_state_t;

endpackage

// *** led_tick_if.sv ***
// Shared millisecond tick and clock enable between timer modules
`timescale 1ns/1ps
`default_nettype none
interface led_tick_if;
  logic msTick;
  logic ce;
  modport src (output msTick, input ce);
  modport dst (input msTick, input ce);
endinterface
`default_nettype wire

// *** ms_tick_gen.sv ***
// Free-running millisecond tick divided from the core clock
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen
#(
  parameter int MS_CYCLES = led_timer_pkg::MS_CYCLES
)
(
  input  wire logic   core_clk,
  input  wire logic   srst,
  led_tick_if.src     tick
);
  logic [17:0] divCnt_r;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
      divCnt_r <= 18'h00000;
    else if (tick.ce)
      divCnt_r <= (divCnt_r == 18'(MS_CYCLES - 1)) ? 18'h00000
                                                    : divCnt_r + 18'h00001;
  end

  assign tick.msTick = tick.ce && (divCnt_r == 18'(MS_CYCLES - 1));

  // Divider must wrap on its tick, or every period drifts
  tickWrap_a: assert property (@(posedge core_clk) disable iff (srst)
    tick.msTick |=> (divCnt_r == 18'h00000))
    else $error("ms divider did not wrap on its tick");
endmodule
`default_nettype wire

// *** period_timer.sv ***
// Period counter on the ms tick; new length loads only at a boundary
`timescale 1ns/1ps
`default_nettype none
module period_timer
(
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  led_tick_if.dst                            tick,
  input  wire logic [led_timer_pkg::PER_W-1:0] limitIn,
  output logic                               boundary
);
  logic [led_timer_pkg::PER_W-1:0] cnt_r;
  logic [led_timer_pkg::PER_W-1:0] lim_r;
  logic                            atEnd;

  assign atEnd    = (cnt_r >= lim_r - 11'h001);
  assign boundary = tick.ce && tick.msTick && atEnd;

  // ----------------------------------------------------------------
  // Counter and latched length
  // ----------------------------------------------------------------
  // Latching the length avoids a cut-short period on a mid-period write
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_r <= 11'h000;
      lim_r <= 11'h001;
    end
    else if (tick.ce && tick.msTick)
    begin
      if (atEnd)
      begin
        cnt_r <= 11'h000;
        lim_r <= limitIn;
      end
      else
        cnt_r <= cnt_r + 11'h001;
    end
  end

  cntBound_a: assert property (@(posedge core_clk) disable iff (srst)
    cnt_r < lim_r)
    else $error("period count passed its length");
  limHold_a: assert property (@(posedge core_clk) disable iff (srst)
    !boundary |=> (lim_r == $past(lim_r)))
    else $error("period length changed off boundary");
endmodule
`default_nettype wire

// *** led_timer_interrupt_ctrl.sv ***
// LED timing, activity stretch and interrupt output control with APB
`timescale 1ns/1ps
`default_nettype none
module led_timer_interrupt_ctrl
#(
  parameter int MS_CYCLES = led_timer_pkg::MS_CYCLES
)
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        intPending,
  input  wire logic        activityIn,
  input  wire logic        ledOnIn,
  input  wire logic        ledBlinkIn,
  input  wire logic        speedBlinkEn,
  output logic             interruptOutN,
  output logic             thirdLedPinO,
  output logic             thirdLedPinOe,
  output logic             activityStretched,
  output logic             blinkPhase,
  output logic             speedPulse
);
  led_tick_if tickBus ();

  logic [15:0]                   timerCtrl_r;
  logic [15:0]                   ledPol_r;
  logic [31:0]                   prdata_r;
  logic                          intActive;
  logic                          intLevel;
  logic                          ledLogic;
  logic                          blinkEdge;
  logic                          strEdge;
  logic                          speedEdge;
  logic                          mapped;
  logic                          wrEn;
  logic [15:0]                   wrMask;
  logic [15:0]                   statusWord;
  logic [2:0]                    strCode;
  logic [1:0]                    ledPolCode;
  logic [led_timer_pkg::PER_W-1:0] blinkLim;
  logic [led_timer_pkg::PER_W-1:0] strLim;
  logic [led_timer_pkg::PER_W-1:0] speedLim;
  led_timer_pkg::stretch_state_t strState_r;
  led_timer_pkg::stretch_state_t strState_nxt;
  led_timer_pkg::speed_state_t   spdState_r;
  led_timer_pkg::speed_state_t   spdState_nxt;

  assign tickBus.ce = ce;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  ms_tick_gen #(.MS_CYCLES(MS_CYCLES)) tickGen
  (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tickBus)
  );

  period_timer blinkTimer
  (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tickBus),
    .limitIn  (blinkLim),
    .boundary (blinkEdge)
  );

  period_timer strTimer
  (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tickBus),
    .limitIn  (strLim),
    .boundary (strEdge)
  );

  period_timer speedTimer
  (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tickBus),
    .limitIn  (speedLim),
    .boundary (speedEdge)
  );

  assign strCode  = timerCtrl_r[led_timer_pkg::STR_HI:led_timer_pkg::STR_LO];
  assign strLim   = led_timer_pkg::STRETCH_MS[strCode];
  assign blinkLim = led_timer_pkg::BLINK_MS[
    timerCtrl_r[led_timer_pkg::BLINK_HI:led_timer_pkg::BLINK_LO]];
  // Length handed over is for the phase that starts at the boundary
  assign speedLim = (spdState_r == led_timer_pkg::SPD_ON)
    ? led_timer_pkg::SPEED_MS[
        timerCtrl_r[led_timer_pkg::OFF_HI:led_timer_pkg::OFF_LO]]
    : led_timer_pkg::SPEED_MS[
        timerCtrl_r[led_timer_pkg::ON_HI:led_timer_pkg::ON_LO]];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign mapped  = (paddr == led_timer_pkg::ADDR_TIMER)
                || (paddr == led_timer_pkg::ADDR_LEDPOL)
                || (paddr == led_timer_pkg::ADDR_STATUS);
  assign pready  = ce;
  assign pslverr = psel && penable && !mapped;
  assign wrEn    = psel && penable && pwrite && ce && mapped;
  assign wrMask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign prdata  = prdata_r;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      timerCtrl_r <= led_timer_pkg::TIMER_RST;
    else if (wrEn && paddr == led_timer_pkg::ADDR_TIMER)
      timerCtrl_r <= (timerCtrl_r & ~(wrMask & led_timer_pkg::TIMER_WMASK))
                   | (pwdata[15:0] & wrMask & led_timer_pkg::TIMER_WMASK);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      ledPol_r <= led_timer_pkg::LEDPOL_RST;
    else if (wrEn && paddr == led_timer_pkg::ADDR_LEDPOL)
      ledPol_r <= (ledPol_r & ~(wrMask & led_timer_pkg::LEDPOL_WMASK))
                | (pwdata[15:0] & wrMask & led_timer_pkg::LEDPOL_WMASK);
  end

  assign statusWord = {11'h000, speedPulse, blinkPhase, activityStretched,
                       thirdLedPinO, intActive};

  // Read data is caught in the setup cycle so the access needs no wait
  always_ff @(posedge core_clk)
  begin
    if (srst)
      prdata_r <= 32'h00000000;
    else if (ce && psel && !penable)
    begin
      case (paddr)
        led_timer_pkg::ADDR_TIMER:  prdata_r <= {16'h0000, timerCtrl_r};
        led_timer_pkg::ADDR_LEDPOL: prdata_r <= {16'h0000, ledPol_r};
        led_timer_pkg::ADDR_STATUS: prdata_r <= {16'h0000, statusWord};
        default:                    prdata_r <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  assign intActive = intPending || timerCtrl_r[led_timer_pkg::FORCE_BIT];
  assign intLevel  = timerCtrl_r[led_timer_pkg::POL_BIT] ^ intActive;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      interruptOutN <= 1'b1;
    else if (ce)
      interruptOutN <= intLevel;
  end

  // ----------------------------------------------------------------
  // Activity stretch
  // ----------------------------------------------------------------
  // Window ends on the second boundary after the last activity
  always_comb
  begin
    strState_nxt = strState_r;
    case (strState_r)
      led_timer_pkg::STR_IDLE:
        if (activityIn && strCode != 3'h0)
          strState_nxt = led_timer_pkg::STR_ARM;
      led_timer_pkg::STR_ARM:
        if (!activityIn && strEdge)
          strState_nxt = led_timer_pkg::STR_HOLD;
      led_timer_pkg::STR_HOLD:
        if (activityIn)
          strState_nxt = led_timer_pkg::STR_ARM;
        else if (strEdge)
          strState_nxt = led_timer_pkg::STR_IDLE;
      default:
        strState_nxt = led_timer_pkg::STR_IDLE;
    endcase
    if (strCode == 3'h0)
      strState_nxt = led_timer_pkg::STR_IDLE;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      strState_r <= led_timer_pkg::STR_IDLE;
    else if (ce)
      strState_r <= strState_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      activityStretched <= 1'b0;
    else if (ce)
      activityStretched <= activityIn
                        || (strState_nxt != led_timer_pkg::STR_IDLE);
  end

  // ----------------------------------------------------------------
  // Blink phase and speed pulses
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
      blinkPhase <= 1'b0;
    else if (blinkEdge)
      blinkPhase <= !blinkPhase;
  end

  always_comb
  begin
    spdState_nxt = spdState_r;
    case (spdState_r)
      led_timer_pkg::SPD_OFF:
        if (speedEdge && speedBlinkEn)
          spdState_nxt = led_timer_pkg::SPD_ON;
      led_timer_pkg::SPD_ON:
        if (speedEdge || !speedBlinkEn)
          spdState_nxt = led_timer_pkg::SPD_OFF;
      default:
        spdState_nxt = led_timer_pkg::SPD_OFF;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      spdState_r <= led_timer_pkg::SPD_OFF;
    else if (ce)
      spdState_r <= spdState_nxt;
  end

  assign speedPulse = (spdState_r == led_timer_pkg::SPD_ON);

  // ----------------------------------------------------------------
  // Third LED pin
  // ----------------------------------------------------------------
  assign ledPolCode = ledPol_r[led_timer_pkg::LPOL_HI:led_timer_pkg::LPOL_LO];
  assign ledLogic   = ledBlinkIn ? (ledOnIn && blinkPhase) : ledOnIn;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      thirdLedPinO  <= 1'b1;
      thirdLedPinOe <= 1'b1;
    end
    else if (ce)
    begin
      if (timerCtrl_r[led_timer_pkg::INTEN_BIT])
      begin
        thirdLedPinO  <= intLevel;
        thirdLedPinOe <= 1'b1;
      end
      else
      begin
        thirdLedPinO  <= ledPolCode[0] ? ledLogic : !ledLogic;
        thirdLedPinOe <= !ledPolCode[1] || ledLogic;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence actSeen;
    ce && activityIn && strCode != 3'h0 && !wrEn;
  endsequence
  sequence heldFour;
    activityStretched [*4];
  endsequence

  forceInt_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && timerCtrl_r[led_timer_pkg::FORCE_BIT])
      |=> (interruptOutN == !$past(timerCtrl_r[led_timer_pkg::POL_BIT])))
    else $error("forced interrupt not asserted");
  intPol_a: assert property (@(posedge core_clk) disable iff (srst)
    ce |=> (interruptOutN == ($past(timerCtrl_r[led_timer_pkg::POL_BIT])
                              ^ $past(intActive))))
    else $error("interrupt output polarity wrong");
  noStretch_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && strCode == 3'h0) |=> (activityStretched == $past(activityIn)))
    else $error("activity stretched while disabled");
  stretchHold_a: assert property (@(posedge core_clk) disable iff (srst)
    actSeen |=> heldFour)
    else $error("activity stretch ended early");
  blinkToggle_a: assert property (@(posedge core_clk) disable iff (srst)
    blinkEdge |=> (blinkPhase != $past(blinkPhase)))
    else $error("blink phase missed a boundary");
  intRoute_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && timerCtrl_r[led_timer_pkg::INTEN_BIT])
      |=> (thirdLedPinOe && thirdLedPinO == $past(intLevel)))
    else $error("interrupt not on third LED");
  ledTri_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && !timerCtrl_r[led_timer_pkg::INTEN_BIT] && ledPolCode[1]
      && !ledLogic) |=> !thirdLedPinOe)
    else $error("third LED driven while off in tristate mode");
  speedOff_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && speedEdge && speedPulse) |=> !speedPulse)
    else $error("speed pulse did not end at boundary");
  speedOn_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && speedEdge && !speedPulse && speedBlinkEn) |=> speedPulse)
    else $error("speed pulse did not start at boundary");
endmodule
`default_nettype wire

// *** led_partner_model.sv ***
// Behavioural model of the indicator wired to the third LED pin
`timescale 1ns/1ps
`default_nettype none
module led_partner_model
(
  input  wire logic core_clk,
  input  wire logic pinO,
  input  wire logic pinOe,
  output logic      pinLevel
);
  logic lastLevel_r;

  // No pull on this net: a released pin shows the inverse, never a held value
  always_ff @(posedge core_clk)
  begin
    if (pinOe)
      lastLevel_r <= pinO;
  end

  assign pinLevel = pinOe ? pinO : ~lastLevel_r;
endmodule
`default_nettype wire

// *** led_timer_interrupt_ctrl_tb.sv ***
// Self-checking bench for the LED timer and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module led_timer_interrupt_ctrl_tb;
  // Short tick keeps the longest tested period near 2700 cycles
  localparam int MSC = 4;
  logic        core_clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        intPending, activityIn, ledOnIn, speedBlinkEn, pinLevel;
  logic        interruptOutN, thirdLedPinO, thirdLedPinOe;
  logic        activityStretched, blinkPhase, speedPulse, ex;
  logic        ce, ledBlinkIn;
  int          nMismatch = 0;
  int          numChecks = 0;
  int          n;
  int          blinkMs [5] = '{42, 84, 170, 340, 670};
  int          spdMs [4] = '{84, 170, 340, 670};

  led_timer_interrupt_ctrl #(.MS_CYCLES(MSC)) dut_u
  (
    .core_clk(core_clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intPending(intPending), .activityIn(activityIn), .ledOnIn(ledOnIn),
    .ledBlinkIn(ledBlinkIn), .speedBlinkEn(speedBlinkEn),
    .interruptOutN(interruptOutN), .thirdLedPinO(thirdLedPinO),
    .thirdLedPinOe(thirdLedPinOe), .activityStretched(activityStretched),
    .blinkPhase(blinkPhase), .speedPulse(speedPulse)
  );

  led_partner_model peer_u
  (
    .core_clk(core_clk), .pinO(thirdLedPinO), .pinOe(thirdLedPinOe),
    .pinLevel(pinLevel)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e)
    begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rng(input int g, input int lo, input int hi);
    numChecks++;
    if (g < lo || g > hi)
    begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask

  // Setup, then access held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic sig(input int s);
    return (s == 0) ? blinkPhase : (s == 1) ? speedPulse : activityStretched;
  endfunction

  // Cycles the chosen output stays at lvl, once it gets there
  task automatic span(input int s, input logic lvl);
    n = 0;
    while (sig(s) !== lvl && n < 9000)
    begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    while (sig(s) === lvl && n < 9000)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    // Tests need about 41000 cycles
    repeat (90000) @(posedge core_clk);
    nMismatch++;
    summarize();
  end

  initial
  begin
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {intPending, activityIn, ledOnIn, speedBlinkEn, ledBlinkIn} = '0;
    ce = 1'b1;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    // Reset values, reserved bits and unmapped place
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h4905);
    apb(1'b1, 8'h48, 32'hFFFF);
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'hFF8F);
    apb(1'b1, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("registers done");
    // Force, pending and polarity, also seen on the third LED
    for (int i = 0; i < 8; i++)
    begin
      intPending <= i[2];
      apb(1'b1, 8'h48, 32'h4185 | (i[0] << 11) | (i[1] << 15));
      repeat (4) @(posedge core_clk);
      ex = (i[1] | i[2]) ^ i[0];
      chk(interruptOutN, ex);
      chk({thirdLedPinOe, thirdLedPinO}, {1'b1, ex});
      apb(1'b0, 8'h4C, 32'h0);
      chk(rd[1:0], {ex, i[1] | i[2]});
    end
    intPending <= 1'b0;
    $display("interrupt done");
    // Third LED drive for every polarity code
    apb(1'b1, 8'h48, 32'h4905);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, 8'h44, c << 4);
      for (int o = 0; o < 2; o++)
      begin
        ledOnIn <= o[0];
        repeat (4) @(posedge core_clk);
        ex = !(c[1] && !o[0]);
        chk(thirdLedPinOe, ex);
        if (ex)
          chk(pinLevel, o[0] ? c[0] : !c[0]);
      end
    end
    // Blinking third LED follows the blink phase one cycle late
    apb(1'b1, 8'h44, 32'h10);
    ledBlinkIn <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      span(0, !p[0]);
      repeat (2) @(posedge core_clk);
      chk(pinLevel, p[0]);
    end
    ledBlinkIn <= 1'b0;
    $display("led polarity done");
    // Blink period for each defined code
    for (int b = 0; b < 5; b++)
    begin
      apb(1'b1, 8'h48, 32'h4805 | (b << 8));
      span(0, 1'b1);
      span(0, 1'b1);
      rng(n, blinkMs[b] * MSC - 2, blinkMs[b] * MSC + 2);
    end
    $display("blink done");
    // Speed on and off pulses, each code in both fields
    speedBlinkEn <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 8'h48, 32'h4900 | ((3 - k) << 2) | k);
      span(1, 1'b1);
      span(1, 1'b1);
      rng(n, spdMs[k] * MSC - 2, spdMs[k] * MSC + 2);
      span(1, 1'b0);
      rng(n, spdMs[3 - k] * MSC - 2, spdMs[3 - k] * MSC + 2);
    end
    speedBlinkEn <= 1'b0;
    $display("speed done");
    // Shortest stretch window, then stretching off
    apb(1'b1, 8'h48, 32'h1905);
    repeat (1500) @(posedge core_clk);
    activityIn <= 1'b1;
    @(posedge core_clk);
    activityIn <= 1'b0;
    span(2, 1'b1);
    rng(n, 21 * MSC - 2, 42 * MSC + 2);
    apb(1'b1, 8'h48, 32'h0905);
    repeat (300) @(posedge core_clk);
    activityIn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(activityStretched, 1'b1);
    activityIn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(activityStretched, 1'b0);
    $display("stretch done");
    // Enable low freezes timers, outputs and the bus handshake
    ce <= 1'b0;
    intPending <= 1'b1;
    @(posedge core_clk);
    ex = blinkPhase;
    repeat (1000) @(posedge core_clk);
    chk(blinkPhase, ex);
    chk(interruptOutN, 1'b1);
    chk(pready, 1'b0);
    ce <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(interruptOutN, 1'b0);
    intPending <= 1'b0;
    $display("enable done");
    summarize();
  end
endmodule
`default_nettype wire
